// [qtb_consts.svh]
/*
 * shared constants of the quadrature timer block: register offsets, control
 * field positions, mode and edge codes, reset values.
 * assumes it is included once per compile unit via its guard.
 */
`ifndef QTB_CONSTS_SVH
`define QTB_CONSTS_SVH

// register offsets (word addresses on the plain register port)
`define QTB_ADDR_CORE_CTRL 4'h0
`define QTB_ADDR_CORE_CNT 4'h1
`define QTB_ADDR_AUXA_CTRL 4'h2
`define QTB_ADDR_AUXA_CNT 4'h3
`define QTB_ADDR_AUXB_CTRL 4'h4
`define QTB_ADDR_AUXB_CNT 4'h5
`define QTB_ADDR_IRQ_STAT 4'h6
`define QTB_ADDR_IRQ_MASK 4'h7

// control register layout, shared by all three timers; the auxiliaries keep only bits 0-8 and 10
`define QTB_F_EDGE_LO 0
`define QTB_F_EDGE_HI 2
`define QTB_F_MODE_LO 3
`define QTB_F_MODE_HI 5
`define QTB_F_RUN 6
`define QTB_F_DIRSW 7
`define QTB_F_EXTDIR 8
`define QTB_F_OTL 9
`define QTB_F_REMOTE 10
`define QTB_F_IRQEN 11
`define QTB_F_CHDIR 12
`define QTB_F_EDGEFLAG 13
`define QTB_F_RDIR 14

// mode codes
`define QTB_MODE_TIMER 3'h0
`define QTB_MODE_COUNTER 3'h1
`define QTB_MODE_GATED_LO 3'h2
`define QTB_MODE_GATED_HI 3'h3
`define QTB_MODE_ENC_ROT 3'h6
`define QTB_MODE_ENC_EDGE 3'h7

// edge select codes in encoder mode
`define QTB_ENC_STOP 3'h0
`define QTB_ENC_CNT 3'h1
`define QTB_ENC_DIR 3'h2
`define QTB_ENC_BOTH 3'h3

// interrupt status bits
`define QTB_IRQ_ENC 0
`define QTB_IRQ_COREOV 1
`define QTB_IRQ_AUXA 2
`define QTB_IRQ_AUXB 3

// reset values and misc
`define QTB_CTRL_RST 16'h0000
`define QTB_CNT_RST 16'h0000
`define QTB_IRQ_RST 4'h0
`define QTB_PRESCALE_BASE 8

`endif

// [qtb_pkg.sv]
/*
 * types of the quadrature timer block.
 * assumes qtb_consts.svh is compiled alongside.
 */
package qtb_pkg;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } qtb_req_t;

    // pin group of the timer block
    typedef struct packed {
        logic coreCountInput;
        logic coreDirectionInput;
        logic auxACountInput;
        logic auxBCountInput;
    } qtb_pins_t;
endpackage : qtb_pkg

// [qtb_quadrature_timer.sv]
/*
 * quadrature timer block: one core timer with timer, gated, counter and
 * encoder modes, two auxiliary timers with the same modes plus counting on
 * the core overflow toggle latch, an interrupt status/mask pair.
 * assumes a single 25 MHz clock, pins asynchronous to it, and software that
 * drives the plain register port one strobe at a time.
 */
// The plain strobed port and the address map are this design's own decisions.
`include "qtb_consts.svh"

//
// Contract
// - modes 110/111 select encoder operation
// - count on selected phase edges, 2x/4x
// - edge select stopped, count, direction, both
// - rotation variant interrupts on direction change
// - edge variant interrupts on each count
// - encoder interrupts need encoder irq enable
// - control shows direction, changed, edge flags
// - direction from edge and other level
// - auxiliaries share timer, gated, counter, encoder modes
// - common fields share bit positions everywhere
// - remote run follows core run bit
// - no toggle latch on auxiliaries
// - aux edge select own input or latch
// - latch toggles on core wrap, software writable
// - only wrap toggles clock auxiliaries
// - all three are 16-bit up/down counters
module qtb_quadrature_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire qtb_pkg::qtb_req_t busReq,
    output logic [15:0] busRdata,
    // pins
    input wire qtb_pkg::qtb_pins_t pins,
    // interrupt and toggle latch
    output logic irqOut,
    output logic toggleLatchOut
);
    import qtb_pkg::*;

    // counters, flags and the read mux are laid out for 16-bit words only
    if (CNT_W != 16) begin : gBadWidth
        $error("CNT_W must be 16");
    end

    // two-flop synchronisers plus one sample stage for edge detection
    logic [3:0] syncA_ff, syncB_ff, prev_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            syncA_ff <= 4'h0;
            syncB_ff <= 4'h0;
            prev_ff <= 4'h0;
        end else begin
            syncA_ff <= pins;
            syncB_ff <= syncA_ff;
            prev_ff <= syncB_ff;
        end
    end
    wire [3:0] rise = syncB_ff & ~prev_ff;
    wire [3:0] fall = ~syncB_ff & prev_ff;
    wire cinLvl = syncB_ff[3];
    wire dinLvl = syncB_ff[2];

    // control and count registers
    logic [15:0] coreCtrl_ff, auxCtrl_ff [2];
    logic [15:0] coreCnt_ff, auxCnt_ff [2];
    logic [3:0] irqStat_ff, irqMask_ff;
    logic [15:0] busRdata_ff;
    logic irqOut_ff;

    // prescaler shared by all timers, base divide by eight
    logic [10:0] preCnt_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) preCnt_ff <= 11'h000;
        else preCnt_ff <= preCnt_ff + 11'h001;
    end

    // tick from a timer's edge field: base 8 times 2 to the field
    function automatic logic preTick(input logic [2:0] sel, input logic [10:0] pc, input logic [10:0] ppc);
        logic [3:0] b;
        b = 4'(sel) + 4'h2;
        preTick = pc[b] & ~ppc[b];
    endfunction
    logic [10:0] preCntPrev_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) preCntPrev_ff <= 11'h000;
        else preCntPrev_ff <= preCnt_ff;
    end

    // core decode
    wire [2:0] coreMode = coreCtrl_ff[`QTB_F_MODE_HI:`QTB_F_MODE_LO];
    wire [2:0] coreSel = coreCtrl_ff[`QTB_F_EDGE_HI:`QTB_F_EDGE_LO];
    wire coreRun = coreCtrl_ff[`QTB_F_RUN];
    wire coreEnc = (coreMode == `QTB_MODE_ENC_ROT) || (coreMode == `QTB_MODE_ENC_EDGE);
    wire cinEdge = rise[3] | fall[3];
    wire dinEdge = rise[2] | fall[2];
    // phase transition selection in encoder mode
    wire encHit = coreSel == `QTB_ENC_CNT ? cinEdge :
                  coreSel == `QTB_ENC_DIR ? dinEdge :
                  coreSel == `QTB_ENC_BOTH ? (cinEdge | dinEdge) : 1'b0;
    // direction from edge type and the other phase level; 1 means down
    wire encDown = cinEdge ? (rise[3] ? dinLvl : ~dinLvl) :
                   (rise[2] ? ~cinLvl : cinLvl);
    wire encCount = coreEnc && coreRun && encHit;
    // software or external direction for the other modes
    wire coreSwDown = coreCtrl_ff[`QTB_F_EXTDIR] ? (dinLvl ^ coreCtrl_ff[`QTB_F_DIRSW])
                                                 : coreCtrl_ff[`QTB_F_DIRSW];

    // generic count enable for non-encoder modes of any timer
    function automatic logic modeTick(input logic [2:0] mode, input logic [2:0] sel, input logic run,
                                      input logic inLvl, input logic inRise, input logic inFall,
                                      input logic tick);
        unique case (mode)
            `QTB_MODE_TIMER: modeTick = run & tick;
            `QTB_MODE_GATED_LO: modeTick = run & tick & ~inLvl;
            `QTB_MODE_GATED_HI: modeTick = run & tick & inLvl;
            `QTB_MODE_COUNTER: modeTick = run & ((sel[0] & inRise) | (sel[1] & inFall));
            default: modeTick = 1'b0;
        endcase
    endfunction
    wire coreTick = preTick(coreSel, preCnt_ff, preCntPrev_ff);
    wire coreStep = coreEnc ? encCount :
                    modeTick(coreMode, coreSel, coreRun, cinLvl, rise[3], fall[3], coreTick);
    wire coreDown = coreEnc ? encDown : coreSwDown;
    wire coreWrap = coreStep && (coreDown ? (coreCnt_ff == 16'h0000) : (coreCnt_ff == 16'hFFFF));

    // encoder flags
    wire dirChange = encCount && (encDown != coreCtrl_ff[`QTB_F_RDIR]);
    wire encIrqEv = coreCtrl_ff[`QTB_F_IRQEN] &&
                    ((coreMode == `QTB_MODE_ENC_ROT && dirChange) ||
                     (coreMode == `QTB_MODE_ENC_EDGE && encCount));

    // register write decode
    wire wrCoreCtrl = busReq.wr && busReq.addr == `QTB_ADDR_CORE_CTRL;
    wire wrCoreCnt = busReq.wr && busReq.addr == `QTB_ADDR_CORE_CNT;
    wire wrStat = busReq.wr && busReq.addr == `QTB_ADDR_IRQ_STAT;
    wire wrMask = busReq.wr && busReq.addr == `QTB_ADDR_IRQ_MASK;

    // core control: software fields, hardware flags win over writes
    logic [15:0] nxt_coreCtrl;
    always_comb begin
        nxt_coreCtrl = coreCtrl_ff;
        if (wrCoreCtrl) nxt_coreCtrl = busReq.wdata;
        nxt_coreCtrl[15] = 1'b0;
        if (coreWrap) nxt_coreCtrl[`QTB_F_OTL] = ~coreCtrl_ff[`QTB_F_OTL];
        if (encCount) nxt_coreCtrl[`QTB_F_RDIR] = encDown;
        if (dirChange) nxt_coreCtrl[`QTB_F_CHDIR] = 1'b1;
        if (encCount) nxt_coreCtrl[`QTB_F_EDGEFLAG] = 1'b1;
    end

    // core counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            coreCtrl_ff <= `QTB_CTRL_RST;
            coreCnt_ff <= `QTB_CNT_RST;
        end else begin
            coreCtrl_ff <= nxt_coreCtrl;
            if (coreStep) coreCnt_ff <= coreDown ? coreCnt_ff - 16'h0001 : coreCnt_ff + 16'h0001;
            else if (wrCoreCnt) coreCnt_ff <= busReq.wdata;
        end
    end

    // latch transitions seen only from wraps, never from software writes
    wire otlRise = coreWrap && !coreCtrl_ff[`QTB_F_OTL];
    wire otlFall = coreWrap && coreCtrl_ff[`QTB_F_OTL];

    // auxiliary timers, identical, one loop
    logic [1:0] auxWrap;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gAux
            localparam logic [3:0] CTRL_A = g ? `QTB_ADDR_AUXB_CTRL : `QTB_ADDR_AUXA_CTRL;
            localparam logic [3:0] CNT_A = g ? `QTB_ADDR_AUXB_CNT : `QTB_ADDR_AUXA_CNT;
            localparam int PIN = 1 - g;
            wire [15:0] ctl = auxCtrl_ff[g];
            wire [2:0] mode = ctl[`QTB_F_MODE_HI:`QTB_F_MODE_LO];
            wire [2:0] sel = ctl[`QTB_F_EDGE_HI:`QTB_F_EDGE_LO];
            wire run = ctl[`QTB_F_REMOTE] ? coreRun : ctl[`QTB_F_RUN];
            wire inL = syncB_ff[PIN];
            // counter mode source picks own pin or the latch
            wire useOtl = sel[2] && mode == `QTB_MODE_COUNTER;
            wire r = useOtl ? otlRise : rise[PIN];
            wire f = useOtl ? otlFall : fall[PIN];
            // encoder mode reuses the core phase pair with the own edge field
            wire encH = sel == `QTB_ENC_CNT ? cinEdge :
                        sel == `QTB_ENC_DIR ? dinEdge :
                        sel == `QTB_ENC_BOTH ? (cinEdge | dinEdge) : 1'b0;
            wire isEnc = mode == `QTB_MODE_ENC_ROT || mode == `QTB_MODE_ENC_EDGE;
            wire step = isEnc ? (run & encH) :
                        modeTick(mode, sel, run, inL, r, f, preTick(sel, preCnt_ff, preCntPrev_ff));
            wire swDown = ctl[`QTB_F_EXTDIR] ? (inL ^ ctl[`QTB_F_DIRSW]) : ctl[`QTB_F_DIRSW];
            wire down = isEnc ? encDown : swDown;
            assign auxWrap[g] = step && (down ? (auxCnt_ff[g] == 16'h0000) : (auxCnt_ff[g] == 16'hFFFF));
            // latch and encoder flag bits are not kept here
            wire [15:0] wmask = ~(16'h0001 << `QTB_F_OTL) & 16'h07FF;
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    auxCtrl_ff[g] <= `QTB_CTRL_RST;
                    auxCnt_ff[g] <= `QTB_CNT_RST;
                end else begin
                    if (busReq.wr && busReq.addr == CTRL_A) auxCtrl_ff[g] <= busReq.wdata & wmask;
                    if (step) auxCnt_ff[g] <= down ? auxCnt_ff[g] - 16'h0001 : auxCnt_ff[g] + 16'h0001;
                    else if (busReq.wr && busReq.addr == CNT_A) auxCnt_ff[g] <= busReq.wdata;
                end
            end
        end
    endgenerate

    // sticky status: set wins over write-one-to-clear
    wire [3:0] irqEv = {auxWrap[1], auxWrap[0], coreWrap, encIrqEv};
    wire [3:0] nxt_irqStat = (irqStat_ff & ~(wrStat ? busReq.wdata[3:0] : 4'h0)) | irqEv;

    // read mux, unmapped reads return zero
    wire [15:0] rdMux = busReq.addr == `QTB_ADDR_CORE_CTRL ? coreCtrl_ff :
                        busReq.addr == `QTB_ADDR_CORE_CNT ? coreCnt_ff :
                        busReq.addr == `QTB_ADDR_AUXA_CTRL ? auxCtrl_ff[0] :
                        busReq.addr == `QTB_ADDR_AUXA_CNT ? auxCnt_ff[0] :
                        busReq.addr == `QTB_ADDR_AUXB_CTRL ? auxCtrl_ff[1] :
                        busReq.addr == `QTB_ADDR_AUXB_CNT ? auxCnt_ff[1] :
                        busReq.addr == `QTB_ADDR_IRQ_STAT ? {12'h000, irqStat_ff} :
                        busReq.addr == `QTB_ADDR_IRQ_MASK ? {12'h000, irqMask_ff} : 16'h0000;

    // status, mask, read data, interrupt line
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqStat_ff <= `QTB_IRQ_RST;
            irqMask_ff <= `QTB_IRQ_RST;
            busRdata_ff <= 16'h0000;
            irqOut_ff <= 1'b0;
        end else begin
            irqStat_ff <= nxt_irqStat;
            if (wrMask) irqMask_ff <= busReq.wdata[3:0];
            busRdata_ff <= busReq.rd ? rdMux : 16'h0000;
            irqOut_ff <= |(nxt_irqStat & (wrMask ? busReq.wdata[3:0] : irqMask_ff));
        end
    end

    assign busRdata = busRdata_ff;
    assign irqOut = irqOut_ff;
    assign toggleLatchOut = coreCtrl_ff[`QTB_F_OTL];
endmodule : qtb_quadrature_timer

// [qtb_quadrature_timer_monitor.sv]
/*
 * port checker of the quadrature timer block.
 * assumes it is bound onto qtb_quadrature_timer and sees one clock domain.
 */
`include "qtb_consts.svh"
module qtb_quadrature_timer_monitor #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire qtb_pkg::qtb_req_t busReq,
    input wire logic [15:0] busRdata,
    // pins and outputs
    input wire qtb_pkg::qtb_pins_t pins,
    input wire logic irqOut,
    input wire logic toggleLatchOut
);
    timeunit 1ns;
    timeprecision 1ps;
    import qtb_pkg::*;
    logic [3:0] maskSh_ff;
    logic runSh_ff;
    wire logic coreCtrlWr = busReq.wr && busReq.addr == `QTB_ADDR_CORE_CTRL;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // shadows of mask and core run, the checker cannot see the registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            maskSh_ff <= 4'h0;
            runSh_ff <= 1'b0;
        end else begin
            if (busReq.wr && busReq.addr == `QTB_ADDR_IRQ_MASK) maskSh_ff <= busReq.wdata[3:0];
            if (coreCtrlWr) runSh_ff <= busReq.wdata[`QTB_F_RUN];
        end
    end
    a_rdata_idle_zero: assert property (!busReq.rd |=> busRdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_reads_zero: assert property (busReq.rd && busReq.addr > 4'h7 |=> busRdata == 16'h0000)
        else $error("unmapped read not zero");
    a_core_top_bit: assert property (busReq.rd && busReq.addr == 4'h0 |=> busRdata[15] == 1'b0)
        else $error("core control bit 15 set");
    a_aux_reserved_zero: assert property (busReq.rd && (busReq.addr == 4'h2 || busReq.addr == 4'h4)
        |=> busRdata[15:11] == 5'h00 && busRdata[9] == 1'b0)
        else $error("aux control reserved bits set");
    a_latch_read_match: assert property (busReq.rd && busReq.addr == 4'h0 |=> busRdata[9] == $past(toggleLatchOut))
        else $error("latch readback differs from pin");
    a_latch_sw_write: assert property (coreCtrlWr && !runSh_ff |=> toggleLatchOut == $past(busReq.wdata[9]))
        else $error("software latch write lost");
    a_latch_stopped_stable: assert property (!runSh_ff && !coreCtrlWr |=> $stable(toggleLatchOut))
        else $error("latch moved while core stopped");
    a_irq_needs_mask: assert property (irqOut |-> maskSh_ff != 4'h0 || $past(maskSh_ff) != 4'h0)
        else $error("interrupt with all sources masked");
endmodule : qtb_quadrature_timer_monitor

// [qtb_encoder_model.sv]
/*
 * incremental encoder driving the two core phase pins.
 * assumes the bench requests single edges through the step task.
 */
module qtb_encoder_model (
    // clock
    input wire logic mclk,
    // phase outputs
    output logic phaseA,
    output logic phaseB
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos = 2'h0;
    // gray order 00,10,11,01 is forward, so only one phase moves per step
    always_comb begin
        phaseA = pos == 2'h1 || pos == 2'h2;
        phaseB = pos[1];
    end
    // one edge per call, then the level stands for hold cycles
    task automatic step(input logic down, input int hold);
        @(posedge mclk);
        pos <= down ? pos - 2'h1 : pos + 2'h1;
        repeat (hold) @(posedge mclk);
    endtask : step
endmodule : qtb_encoder_model

// [test_qtb_quadrature_timer.sv]
/*
 * self-checking bench of the quadrature timer block.
 * assumes the monitor and encoder model are compiled before this file.
 */
module test_qtb_quadrature_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import qtb_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    qtb_req_t busReq = '0;
    logic [15:0] busRdata;
    qtb_pins_t pins;
    logic irqOut;
    logic toggleLatchOut;
    logic phA;
    logic phB;
    logic auxB = 1'b0;
    logic [15:0] rdVal;
    int errors = 0;
    int tests_run = 0;
    assign pins = {phA, phB, 1'b0, auxB};
    qtb_quadrature_timer #(.CNT_W(16)) i_dut (.mclk(mclk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
        .pins(pins), .irqOut(irqOut), .toggleLatchOut(toggleLatchOut));
    qtb_encoder_model i_enc (.mclk(mclk), .phaseA(phA), .phaseB(phB));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq.wr <= 1'b0;
        // outputs launched by the write edge are settled by the falling edge
        @(negedge mclk);
    endtask : regWrite
    // data stands only in the cycle after the strobe, so sample mid-cycle
    task automatic regRead(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        @(negedge mclk);
        v = busRdata;
    endtask : regRead
    task automatic expectReg(input string what, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        regRead(a, v);
        check(what, v, exp);
    endtask : expectReg
    // alternate prompt and slow encoder steps
    task automatic moves(input int n, input logic down);
        for (int i = 0; i < n; i++) begin
            i_enc.step(down, 4 + (i % 2) * 8);
        end
    endtask : moves
    task automatic auxPulses(input int n);
        repeat (n) begin
            @(posedge mclk);
            auxB <= 1'b1;
            repeat (6) @(posedge mclk);
            auxB <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask : auxPulses
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        wrap_up();
    end
    initial begin
        int cnt[4] = '{0, 2, 2, 4};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            expectReg("reset value", a[3:0], 16'h0000);
        end
        $display("test reset done");
        regWrite(4'h7, 16'h0001);
        regWrite(4'h0, 16'h0973);
        moves(4, 1'b0);
        expectReg("count up", 4'h1, 16'h0004);
        moves(2, 1'b1);
        expectReg("count down", 4'h1, 16'h0002);
        regRead(4'h0, rdVal);
        check("direction flags", rdVal & 16'hDFFF, 16'h5973);
        check("irq", {15'h0000, irqOut}, 16'h0001);
        expectReg("status", 4'h6, 16'h0001);
        regWrite(4'h6, 16'h000F);
        regWrite(4'h0, 16'h0973);
        check("irq cleared", {15'h0000, irqOut}, 16'h0000);
        $display("test rotation done");
        for (int c = 0; c < 4; c++) begin
            regWrite(4'h0, 16'h0978 | 16'(c));
            regWrite(4'h1, 16'h0000);
            regWrite(4'h6, 16'h000F);
            moves(4, 1'b0);
            expectReg("edge count", 4'h1, 16'(cnt[c]));
            expectReg("edge status", 4'h6, {15'h0000, c != 0});
        end
        regWrite(4'h0, 16'h017B);
        regWrite(4'h6, 16'h000F);
        moves(2, 1'b0);
        expectReg("irq disabled", 4'h6, 16'h0000);
        $display("test edge done");
        regWrite(4'h2, 16'h004F);
        regWrite(4'h1, 16'hFFFF);
        moves(1, 1'b0);
        expectReg("core wrap", 4'h1, 16'h0000);
        check("latch", {15'h0000, toggleLatchOut}, 16'h0001);
        expectReg("aux a count", 4'h3, 16'h0001);
        regWrite(4'h0, 16'h007B);
        expectReg("aux a sw", 4'h3, 16'h0001);
        check("wrap masked", {15'h0000, irqOut}, 16'h0000);
        regWrite(4'h7, 16'h0002);
        check("wrap irq", {15'h0000, irqOut}, 16'h0001);
        regWrite(4'h6, 16'h0002);
        check("wrap cleared", {15'h0000, irqOut}, 16'h0000);
        $display("test latch done");
        regWrite(4'h0, 16'h0000);
        regWrite(4'h4, 16'h0409);
        expectReg("aux b ctrl", 4'h4, 16'h0409);
        auxPulses(2);
        expectReg("remote stopped", 4'h5, 16'h0000);
        regWrite(4'h0, 16'h0040);
        auxPulses(2);
        expectReg("remote running", 4'h5, 16'h0002);
        regWrite(4'h0, 16'h0000);
        regWrite(4'h0, 16'h0200);
        check("latch set", {15'h0000, toggleLatchOut}, 16'h0001);
        expectReg("aux a after set", 4'h3, 16'h0001);
        regWrite(4'h4, 16'h0079);
        moves(2, 1'b0);
        expectReg("aux encoder", 4'h5, 16'h0003);
        $display("test remote done");
        wrap_up();
    end
endmodule : test_qtb_quadrature_timer

bind qtb_quadrature_timer qtb_quadrature_timer_monitor #(.CNT_W(CNT_W)) i_mon (.mclk(mclk), .rst(rst),
    .busReq(busReq), .busRdata(busRdata), .pins(pins), .irqOut(irqOut), .toggleLatchOut(toggleLatchOut));
